// ==== include/carc_pkg.sv ====
// Constants for the circular-address and repeat-control block.
// Assumes a 16-bit data path and a page-0 register port.
package carc_pkg;
   localparam int unsigned DW = 16;
   // ----------------------------------------------------------------
   // Register indices inside data page 0
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_AUX_BASE = 7'h10;
   localparam logic [6:0] ADDR_CSA1 = 7'h1e;
   localparam logic [6:0] ADDR_CSA2 = 7'h1f;
   localparam logic [6:0] ADDR_CEA1 = 7'h20;
   localparam logic [6:0] ADDR_CEA2 = 7'h21;
   localparam logic [6:0] ADDR_CCTL = 7'h22;
   localparam logic [6:0] ADDR_RCNT = 7'h23;
   localparam logic [6:0] ADDR_BRCNT = 7'h24;
   localparam logic [6:0] ADDR_STAT = 7'h25;
   localparam logic [6:0] ADDR_IO_BASE = 7'h50;
   localparam logic [6:0] ADDR_IO_MASK = 7'h70;
   // ----------------------------------------------------------------
   // Control register layout
   // ----------------------------------------------------------------
   localparam int unsigned CC_SEL1_LSB = 0;
   localparam int unsigned CC_EN1_BIT = 3;
   localparam int unsigned CC_SEL2_LSB = 4;
   localparam int unsigned CC_EN2_BIT = 7;
   localparam logic [15:0] CCTL_RESET = 16'h0000;
   localparam int unsigned BLOCK_MIN_LEN = 3;
   localparam int unsigned N_AUX = 8;
   localparam int unsigned N_IO = 16;
   typedef enum logic [1:0]
   {
      CARC_IDLE = 2'b00,
      CARC_FETCH = 2'b01,
      CARC_REPEAT = 2'b10
   } carc_state_t;
endpackage

// ==== rtl/carc_circ_step.sv ====
// Postincrement step of one circular pointer.
// Assumes start and end addresses already loaded by software.
`timescale 1ns/1ps
module carc_circ_step #(parameter int unsigned W = 16)
(
   input wire logic i_en,
   input wire logic [W-1:0] i_ptr,
   input wire logic [W-1:0] i_start,
   input wire logic [W-1:0] i_end,
   input wire logic [W-1:0] i_step,
   output logic [W-1:0] o_next,
   output logic o_wrap
);
   // Wrap only after the end address itself was used
   always_comb
   begin
      o_wrap = i_en && (i_ptr == i_end);
      if (o_wrap)
      begin
         o_next = i_start;
      end
      else
      begin
         o_next = i_ptr + i_step;
      end
   end
endmodule

// ==== rtl/carc_top.sv ====
// Circular addressing, block repeat and single repeat control.
// Assumes the core pipeline drives one access request per cycle.
// What this block does
// - Two concurrent circular buffers via aux pointers
// - Five mapped registers govern circular buffers
// - Pointer at end reloads start on postincrement
// - Control 0fh enables buffer one, pointer seven
// - Aux registers mapped in data page zero
// - Block loops of 3 to 65536 words
// - Block end jumps to start, no cycles
// - Block loops stay interruptible
// - Sixteen-bit single repeat counter
// - Operand N gives N plus one executions
// - Repeated instruction fetched once and latched
// - Repeated multicycle instructions take one cycle
// - Program bus moves second operand in parallel
// - Program counter holds second address, increments
// - Each cycle increments operand address, decrements counter until it is zero
// - Repeated input rewrites the one I/O location on i_addr
// - Sixteen I/O ports mapped in page zero
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module carc_top #(parameter int unsigned W = 16)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [6:0] i_addr,
   input wire logic [W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [W-1:0] o_rdata,
   input wire logic i_acc_valid,
   input wire logic [2:0] i_acc_sel,
   input wire logic [W-1:0] i_acc_step,
   input wire logic i_pc_valid,
   input wire logic [W-1:0] i_pc,
   input wire logic i_rpt_start,
   input wire logic [W-1:0] i_rpt_count,
   input wire logic [W-1:0] i_rpt_addr2,
   input wire logic [W-1:0] i_instr,
   input wire logic i_blk_start,
   input wire logic [W-1:0] i_blk_begin,
   input wire logic [W-1:0] i_blk_end,
   input wire logic [W-1:0] i_blk_count,
   input wire logic i_irq_take,
   input wire logic [W-1:0] i_io_in,
   output logic [W-1:0] o_aux_ptr,
   output logic o_fetch_en,
   output logic [W-1:0] o_instr,
   output logic o_rpt_active,
   output logic [W-1:0] o_prog_addr,
   output logic o_pc_load,
   output logic [W-1:0] o_pc_next,
   output logic o_blk_active,
   output logic [W-1:0] o_io_out
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [W-1:0] aux_ff [carc_pkg::N_AUX];
   logic [W-1:0] nxt_aux [carc_pkg::N_AUX];
   logic [W-1:0] io_ff [carc_pkg::N_IO];
   logic [W-1:0] nxt_io [carc_pkg::N_IO];
   logic [W-1:0] csa1_ff, csa2_ff, cea1_ff, cea2_ff, cctl_ff;
   logic [W-1:0] nxt_csa1, nxt_csa2, nxt_cea1, nxt_cea2, nxt_cctl;
   logic [W-1:0] rdata_ff, nxt_rdata;
   logic [W-1:0] ptr1, nx1, nx2;
   logic [2:0] sel1, sel2;
   logic en1, en2, wrap1, wrap2;
   logic io_sel;
   logic [3:0] io_idx;

   assign sel1 = cctl_ff[carc_pkg::CC_SEL1_LSB +: 3];
   assign sel2 = cctl_ff[carc_pkg::CC_SEL2_LSB +: 3];
   assign en1 = cctl_ff[carc_pkg::CC_EN1_BIT];
   assign en2 = cctl_ff[carc_pkg::CC_EN2_BIT];
   assign ptr1 = aux_ff[i_acc_sel];
   assign io_sel = (i_addr & carc_pkg::ADDR_IO_MASK) ==
      carc_pkg::ADDR_IO_BASE;
   assign io_idx = i_addr[3:0];

   // Two buffers evaluated side by side
   carc_circ_step #(.W(W)) u_step1
   (
      .i_en(en1 && (sel1 == i_acc_sel)),
      .i_ptr(ptr1),
      .i_start(csa1_ff),
      .i_end(cea1_ff),
      .i_step(i_acc_step),
      .o_next(nx1),
      .o_wrap(wrap1)
   );
   carc_circ_step #(.W(W)) u_step2
   (
      .i_en(en2 && (sel2 == i_acc_sel)),
      .i_ptr(ptr1),
      .i_start(csa2_ff),
      .i_end(cea2_ff),
      .i_step(i_acc_step),
      .o_next(nx2),
      .o_wrap(wrap2)
   );

   // ----------------------------------------------------------------
   // Repeat state
   // ----------------------------------------------------------------
   carc_pkg::carc_state_t st_ff, nxt_st;
   logic [W-1:0] rcnt_ff, nxt_rcnt;
   logic [W-1:0] instr_ff, nxt_instr;
   logic [W-1:0] paddr_ff, nxt_paddr;
   logic blk_ff, nxt_blk;
   logic [W-1:0] bcnt_ff, nxt_bcnt;
   logic [W-1:0] bbeg_ff, nxt_bbeg, bend_ff, nxt_bend;
   logic rpt_step;

   assign rpt_step = (st_ff == carc_pkg::CARC_REPEAT);

   always_comb
   begin
      nxt_aux = aux_ff;
      nxt_io = io_ff;
      nxt_csa1 = csa1_ff;
      nxt_csa2 = csa2_ff;
      nxt_cea1 = cea1_ff;
      nxt_cea2 = cea2_ff;
      nxt_cctl = cctl_ff;
      // Pointer update, end address included in range
      if (i_acc_valid)
      begin
         if (en1 && sel1 == i_acc_sel)
            nxt_aux[i_acc_sel] = nx1;
         else if (en2 && sel2 == i_acc_sel)
            nxt_aux[i_acc_sel] = nx2;
         else
            nxt_aux[i_acc_sel] = aux_ff[i_acc_sel] + i_acc_step;
      end
      // Repeated input moves the port word to the I/O location on i_addr
      if (rpt_step && io_sel)
         nxt_io[io_idx] = i_io_in;
      // Software write wins over a hardware update in the same cycle
      if (i_wr)
      begin
         if (i_addr >= carc_pkg::ADDR_AUX_BASE &&
            i_addr < carc_pkg::ADDR_AUX_BASE + 7'h08)
            nxt_aux[i_addr[2:0]] = i_wdata;
         if (io_sel)
            nxt_io[io_idx] = i_wdata;
         unique case (i_addr)
            carc_pkg::ADDR_CSA1: nxt_csa1 = i_wdata;
            carc_pkg::ADDR_CSA2: nxt_csa2 = i_wdata;
            carc_pkg::ADDR_CEA1: nxt_cea1 = i_wdata;
            carc_pkg::ADDR_CEA2: nxt_cea2 = i_wdata;
            carc_pkg::ADDR_CCTL: nxt_cctl = i_wdata;
            default: nxt_cctl = nxt_cctl;
         endcase
      end
   end

   // Read decode; unmapped addresses read zero
   always_comb
   begin
      nxt_rdata = '0;
      if (i_rd)
      begin
         if (i_addr >= carc_pkg::ADDR_AUX_BASE &&
            i_addr < carc_pkg::ADDR_AUX_BASE + 7'h08)
            nxt_rdata = aux_ff[i_addr[2:0]];
         else if (io_sel)
            nxt_rdata = io_ff[io_idx];
         else
         begin
            unique case (i_addr)
               carc_pkg::ADDR_CSA1: nxt_rdata = csa1_ff;
               carc_pkg::ADDR_CSA2: nxt_rdata = csa2_ff;
               carc_pkg::ADDR_CEA1: nxt_rdata = cea1_ff;
               carc_pkg::ADDR_CEA2: nxt_rdata = cea2_ff;
               carc_pkg::ADDR_CCTL: nxt_rdata = cctl_ff;
               carc_pkg::ADDR_RCNT: nxt_rdata = rcnt_ff;
               carc_pkg::ADDR_BRCNT: nxt_rdata = bcnt_ff;
               carc_pkg::ADDR_STAT: nxt_rdata = {14'h0000, blk_ff, rpt_step};
               default: nxt_rdata = '0;
            endcase
         end
      end
   end

   // Single repeat and block repeat sequencing
   always_comb
   begin
      nxt_st = st_ff;
      nxt_rcnt = rcnt_ff;
      nxt_instr = instr_ff;
      nxt_paddr = paddr_ff;
      nxt_blk = blk_ff;
      nxt_bcnt = bcnt_ff;
      nxt_bbeg = bbeg_ff;
      nxt_bend = bend_ff;
      unique case (st_ff)
         carc_pkg::CARC_IDLE:
         begin
            if (i_rpt_start)
            begin
               nxt_rcnt = i_rpt_count;
               nxt_paddr = i_rpt_addr2;
               nxt_st = carc_pkg::CARC_FETCH;
            end
         end
         carc_pkg::CARC_FETCH:
         begin
            nxt_instr = i_instr;
            nxt_st = carc_pkg::CARC_REPEAT;
         end
         carc_pkg::CARC_REPEAT:
         begin
            // One execution per cycle, count+1 in all
            nxt_paddr = paddr_ff + 16'h0001;
            if (rcnt_ff == 16'h0000)
               nxt_st = carc_pkg::CARC_IDLE;
            else
               nxt_rcnt = rcnt_ff - 16'h0001;
         end
      endcase
      if (i_blk_start)
      begin
         nxt_blk = 1'b1;
         nxt_bcnt = i_blk_count;
         nxt_bbeg = i_blk_begin;
         nxt_bend = i_blk_end;
      end
      else if (blk_ff && i_pc_valid && i_pc == bend_ff && !i_irq_take)
      begin
         if (bcnt_ff == 16'h0000)
            nxt_blk = 1'b0;
         else
            nxt_bcnt = bcnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aux_ff <= '{default: '0};
         io_ff <= '{default: '0};
         csa1_ff <= '0;
         csa2_ff <= '0;
         cea1_ff <= '0;
         cea2_ff <= '0;
         cctl_ff <= carc_pkg::CCTL_RESET;
         rdata_ff <= '0;
         st_ff <= carc_pkg::CARC_IDLE;
         rcnt_ff <= '0;
         instr_ff <= '0;
         paddr_ff <= '0;
         blk_ff <= 1'b0;
         bcnt_ff <= '0;
         bbeg_ff <= '0;
         bend_ff <= '0;
      end
      else
      begin
         aux_ff <= nxt_aux;
         io_ff <= nxt_io;
         csa1_ff <= nxt_csa1;
         csa2_ff <= nxt_csa2;
         cea1_ff <= nxt_cea1;
         cea2_ff <= nxt_cea2;
         cctl_ff <= nxt_cctl;
         rdata_ff <= nxt_rdata;
         st_ff <= nxt_st;
         rcnt_ff <= nxt_rcnt;
         instr_ff <= nxt_instr;
         paddr_ff <= nxt_paddr;
         blk_ff <= nxt_blk;
         bcnt_ff <= nxt_bcnt;
         bbeg_ff <= nxt_bbeg;
         bend_ff <= nxt_bend;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rdata = rdata_ff;
   assign o_aux_ptr = aux_ff[i_acc_sel];
   assign o_fetch_en = !rpt_step;
   assign o_instr = instr_ff;
   assign o_rpt_active = rpt_step;
   assign o_prog_addr = paddr_ff;
   // Loop back is taken in the same cycle as the end fetch
   assign o_pc_load = blk_ff && i_pc_valid && i_pc == bend_ff &&
      bcnt_ff != 16'h0000 && !i_irq_take;
   assign o_pc_next = bbeg_ff;
   assign o_blk_active = blk_ff;
   assign o_io_out = io_ff[io_idx];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_wrap_to_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_acc_valid && !i_wr && en1 && sel1 == i_acc_sel &&
      aux_ff[i_acc_sel] == cea1_ff |=> aux_ff[$past(i_acc_sel)] ==
      $past(csa1_ff))
      else $error("pointer did not wrap to start");
   a_repeat_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_ff == carc_pkg::CARC_FETCH && rcnt_ff == 16'h0002 |=>
      rpt_step [*3] ##1 !rpt_step)
      else $error("repeat count wrong");
   a_fetch_once: assert property (@(posedge i_clk) disable iff (!i_nrst)
      rpt_step |-> !o_fetch_en ##1 $stable(instr_ff))
      else $error("fetch during repeat");
   a_addr_incr: assert property (@(posedge i_clk) disable iff (!i_nrst)
      rpt_step |=> paddr_ff == $past(paddr_ff) + 16'h0001)
      else $error("operand address not incremented");
   a_block_loop: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_pc_load && !i_blk_start |-> o_pc_next == bbeg_ff ##1
      (blk_ff && bcnt_ff == $past(bcnt_ff) - 16'h0001))
      else $error("block loop back wrong");
   a_irq_open: assert property (@(posedge i_clk) disable iff (!i_nrst)
      blk_ff && i_irq_take && !i_blk_start |-> !o_pc_load ##1
      (blk_ff && bcnt_ff == $past(bcnt_ff)))
      else $error("loop blocked interrupt");
   a_ctl_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_wr && i_addr == carc_pkg::ADDR_CCTL && i_wdata == 16'h000f |=>
      en1 && sel1 == 3'h7 && !en2)
      else $error("control write not applied");
   a_aux_mapped: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_wr && i_addr >= carc_pkg::ADDR_AUX_BASE &&
      i_addr < carc_pkg::ADDR_AUX_BASE + 7'h08 |=>
      aux_ff[$past(i_addr[2:0])] == $past(i_wdata))
      else $error("aux write lost");
endmodule

// ==== tb/test_carc_top.sv ====
// Self-checking bench for the circular-address and repeat-control block.
// Assumes carc_pkg and the rtl files are compiled before it.
`timescale 1ns/1ps
module test_carc_top;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [6:0] i_addr = 7'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_acc_valid = 1'b0;
   logic [2:0] i_acc_sel = 3'h0;
   logic [15:0] i_acc_step = 16'h0001;
   logic i_pc_valid = 1'b0;
   logic [15:0] i_pc = 16'h0000;
   logic i_rpt_start = 1'b0;
   logic [15:0] i_rpt_count = 16'h0000;
   logic [15:0] i_rpt_addr2 = 16'h0000;
   logic [15:0] i_instr = 16'h0000;
   logic i_blk_start = 1'b0;
   logic [15:0] i_blk_begin = 16'h0000;
   logic [15:0] i_blk_end = 16'h0000;
   logic [15:0] i_blk_count = 16'h0000;
   logic i_irq_take = 1'b0;
   logic [15:0] i_io_in = 16'h0000;
   logic [15:0] o_rdata;
   logic [15:0] o_aux_ptr;
   logic o_fetch_en;
   logic [15:0] o_instr;
   logic o_rpt_active;
   logic [15:0] o_prog_addr;
   logic o_pc_load;
   logic [15:0] o_pc_next;
   logic o_blk_active;
   logic [15:0] o_io_out;
   int errors = 0;
   int checks = 0;
   int n;
   logic [6:0] r_a [0:5] = '{7'h17, 7'h1e, 7'h1f, 7'h20, 7'h21, 7'h7f};
   logic [15:0] r_d [0:5] = '{16'h0300, 16'h0300, 16'h0400, 16'h0302,
                              16'h0401, 16'hffff};
   logic [15:0] r_e [0:5] = '{16'h0300, 16'h0300, 16'h0400, 16'h0302,
                              16'h0401, 16'h0000};

   carc_top #(.W(16)) dut
   (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .i_acc_valid(i_acc_valid),
      .i_acc_sel(i_acc_sel),
      .i_acc_step(i_acc_step),
      .i_pc_valid(i_pc_valid),
      .i_pc(i_pc),
      .i_rpt_start(i_rpt_start),
      .i_rpt_count(i_rpt_count),
      .i_rpt_addr2(i_rpt_addr2),
      .i_instr(i_instr),
      .i_blk_start(i_blk_start),
      .i_blk_begin(i_blk_begin),
      .i_blk_end(i_blk_end),
      .i_blk_count(i_blk_count),
      .i_irq_take(i_irq_take),
      .i_io_in(i_io_in),
      .o_aux_ptr(o_aux_ptr),
      .o_fetch_en(o_fetch_en),
      .o_instr(o_instr),
      .o_rpt_active(o_rpt_active),
      .o_prog_addr(o_prog_addr),
      .o_pc_load(o_pc_load),
      .o_pc_next(o_pc_next),
      .o_blk_active(o_blk_active),
      .o_io_out(o_io_out)
   );

   always #4 i_clk = ~i_clk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk("rdata", e, o_rdata);
   endtask

   // One postincrement access, then compare the pointer it left
   task automatic step(input logic [2:0] s, input logic [15:0] st,
                       input logic [15:0] e);
      @(posedge i_clk);
      i_acc_valid <= 1'b1;
      i_acc_sel <= s;
      i_acc_step <= st;
      @(posedge i_clk);
      i_acc_valid <= 1'b0;
      @(negedge i_clk);
      chk("aux_ptr", e, o_aux_ptr);
   endtask

   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      #20000;
      errors++;
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         wr(r_a[k], r_d[k]);
         rd(r_a[k], r_e[k]);
      end
      $display("test register table done");
      @(posedge i_clk);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(carc_pkg::ADDR_CCTL, 16'h0000);
      rd(7'h17, 16'h0000);
      chk("fetch_en", 16'h0001, {15'h0, o_fetch_en});
      $display("test reset done");
      wr(carc_pkg::ADDR_CSA1, 16'h0300);
      wr(carc_pkg::ADDR_CEA1, 16'h0302);
      wr(7'h17, 16'h0300);
      wr(carc_pkg::ADDR_CCTL, 16'h000f);
      for (int k = 1; k < 4; k++)
         step(3'h7, 16'h0001, 16'h0300 + 16'(k % 3));
      wr(carc_pkg::ADDR_CCTL, 16'h000f & 16'hfff7);
      step(3'h7, 16'h0001, 16'h0301);
      step(3'h7, 16'h0001, 16'h0302);
      step(3'h7, 16'h0001, 16'h0303);
      wr(carc_pkg::ADDR_CSA2, 16'h0400);
      wr(carc_pkg::ADDR_CEA2, 16'h0401);
      wr(7'h13, 16'h0401);
      wr(carc_pkg::ADDR_CCTL, 16'h00bf);
      step(3'h3, 16'h0001, 16'h0400);
      wr(7'h17, 16'h0302);
      step(3'h7, 16'h0001, 16'h0300);
      step(3'h7, 16'h0002, 16'h0302);
      step(3'h7, 16'h0002, 16'h0300);
      $display("test circular done");
      for (int c = 3; c > 1; c--)
      begin
         @(posedge i_clk);
         i_rpt_start <= 1'b1;
         i_rpt_count <= 16'(c);
         i_rpt_addr2 <= 16'h0800;
         i_instr <= 16'h5a30 + 16'(c);
         i_addr <= carc_pkg::ADDR_IO_BASE | 7'h02;
         i_io_in <= 16'h1230 + 16'(c);
         @(posedge i_clk);
         i_rpt_start <= 1'b0;
         @(posedge i_clk);
         i_instr <= 16'h0000;
         n = 0;
         repeat (12)
         begin
            @(negedge i_clk);
            if (o_rpt_active === 1'b1)
            begin
               chk("prog_addr", 16'h0800 + 16'(n), o_prog_addr);
               chk("fetch_en", 16'h0000, {15'h0, o_fetch_en});
               n++;
            end
         end
         chk("repeat_cycles", 16'(c + 1), 16'(n));
         chk("instr", 16'h5a30 + 16'(c), o_instr);
         chk("io_in", 16'h1230 + 16'(c), o_io_out);
      end
      $display("test single repeat done");
      @(posedge i_clk);
      i_blk_start <= 1'b1;
      i_blk_begin <= 16'h0100;
      i_blk_end <= 16'h0104;
      i_blk_count <= 16'h0001;
      @(posedge i_clk);
      i_blk_start <= 1'b0;
      @(negedge i_clk);
      chk("blk_active", 16'h0001, {15'h0, o_blk_active});
      @(posedge i_clk);
      i_pc_valid <= 1'b1;
      i_pc <= 16'h0104;
      @(negedge i_clk);
      chk("pc_load", 16'h0001, {15'h0, o_pc_load});
      @(negedge i_clk);
      chk("pc_next", 16'h0100, o_pc_next);
      chk("pc_load", 16'h0000, {15'h0, o_pc_load});
      @(posedge i_clk);
      i_pc_valid <= 1'b0;
      @(negedge i_clk);
      chk("blk_active", 16'h0000, {15'h0, o_blk_active});
      @(posedge i_clk);
      i_blk_start <= 1'b1;
      @(posedge i_clk);
      i_blk_start <= 1'b0;
      i_pc_valid <= 1'b1;
      i_irq_take <= 1'b1;
      @(negedge i_clk);
      chk("pc_load", 16'h0000, {15'h0, o_pc_load});
      @(posedge i_clk);
      i_pc_valid <= 1'b0;
      i_irq_take <= 1'b0;
      $display("test block repeat done");
      wr(carc_pkg::ADDR_IO_BASE | 7'h01, 16'hbeef);
      @(posedge i_clk);
      i_addr <= carc_pkg::ADDR_IO_BASE | 7'h01;
      @(negedge i_clk);
      chk("io_out", 16'hbeef, o_io_out);
      $display("test io port done");
      results();
   end
endmodule
